//--- srr_read.sv
`timescale 1ns/1ps
// Function
// - chip select low starts a read; opcode 48h selects this read
// - 24-bit address then eight dummy clocks precede any output data
// - opcode and address bits are sampled on serial clock rising edge
// - data bytes leave msb first, bits changing on falling edge
// - byte address advances by one after each byte sent
// - after byte FFh the address wraps to 00h of the same register
// - chip select high ends output; device awaits a new instruction
// - read arriving while busy is ignored and leaves the cycle alone
// - address: bits 23-16 and 11-8 zero, 15-12 pick register 1-3
// - busy bit stays one through a self-timed cycle, then clears

// ----------------------------------------
// dual-clock fifo, gray pointers
// ----------------------------------------
module srr_afifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic i_wclk,
  input wire logic i_wrst_n,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_rclk,
  input wire logic i_rrst_n,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [W-1:0] o_rdata
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [0:DEPTH-1];
  logic [AW:0] wbin_ff, wgray_ff, rq1_ff, rq2_ff, nxt_wbin;
  logic [AW:0] rbin_ff, rgray_ff, wq1_ff, wq2_ff, nxt_rbin;
  logic push, pop;

  // write side: full when pointers differ only in top two gray bits
  always_comb begin
    o_wready = wgray_ff != {~rq2_ff[AW:AW-1], rq2_ff[AW-2:0]};
    push = i_wvalid && o_wready;
    nxt_wbin = push ? wbin_ff + 1'b1 : wbin_ff;
  end

  always_ff @(posedge i_wclk) begin
    if (!i_wrst_n) begin
      wbin_ff <= '0;
      wgray_ff <= '0;
      rq1_ff <= '0;
      rq2_ff <= '0;
    end else begin
      wbin_ff <= nxt_wbin;
      wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
      rq1_ff <= rgray_ff;
      rq2_ff <= rq1_ff;
    end
  end

  // storage, written on the write clock only
  always_ff @(posedge i_wclk) begin
    if (push) begin
      mem_ff[wbin_ff[AW-1:0]] <= i_wdata;
    end
  end

  // read side: link clock may stop, so reset is asynchronous
  always_comb begin
    o_rvalid = rgray_ff != wq2_ff;
    pop = o_rvalid && i_rready;
    nxt_rbin = pop ? rbin_ff + 1'b1 : rbin_ff;
    o_rdata = mem_ff[rbin_ff[AW-1:0]];
  end

  always_ff @(posedge i_rclk or negedge i_rrst_n) begin
    if (!i_rrst_n) begin
      rbin_ff <= '0;
      rgray_ff <= '0;
      wq1_ff <= '0;
      wq2_ff <= '0;
    end else begin
      rbin_ff <= nxt_rbin;
      rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
      wq1_ff <= wgray_ff;
      wq2_ff <= wq1_ff;
    end
  end
endmodule // srr_afifo

// ----------------------------------------
// security register read, device side
// ----------------------------------------
module srr_read (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in_pin,
  output logic o_so,
  output logic o_so_oe,
  input wire logic i_cycle_start,
  input wire logic i_cycle_done,
  output logic o_busy,
  input wire logic i_wr_en,
  input wire logic [1:0] i_wr_reg,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data
);
  srr_pkg::srr_state_t st_ff, nxt_st;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [22:0] sr_ff, nxt_sr;
  logic [7:0] sh_ff, nxt_sh;
  logic b1_ff, b2_ff;
  logic tog_ff, nxt_tog;
  logic [1:0] lreg_ff, nxt_lreg;
  logic [7:0] lstart_ff, nxt_lstart;
  logic so_ff, oe_ff;
  logic [23:0] adr_full;
  logic [7:0] opc_full;
  logic adr_ok, load, rvalid, rready, wvalid, wready;
  logic [8:0] rdata, wdata;
  logic [7:0] mem_ff [0:srr_pkg::NUM_REGS-1][0:srr_pkg::REG_BYTES-1];
  logic t1_ff, t2_ff, seen_ff, act_ff, tag_ff, busy_ff, newreq;
  logic nxt_seen, nxt_act, nxt_tag, nxt_busy;
  logic [1:0] reg_ff, nxt_reg;
  logic [7:0] ptr_ff, nxt_ptr;

  // ----------------------------------------
  // link side, rising edge of serial clock, output pin on falling edge
  // ----------------------------------------
  // decode opcode, address, dummy phase and byte loads
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_sr = {sr_ff[21:0], i_serial_in_pin};
    nxt_sh = {sh_ff[6:0], 1'b0};
    nxt_tog = tog_ff;
    nxt_lreg = lreg_ff;
    nxt_lstart = lstart_ff;
    opc_full = {sr_ff[6:0], i_serial_in_pin};
    adr_full = {sr_ff, i_serial_in_pin};
    adr_ok = adr_full[23:16] == srr_pkg::ADR_HI_ZERO
      && adr_full[11:8] == srr_pkg::ADR_MID_ZERO
      && adr_full[15:12] >= srr_pkg::REG_SEL_MIN
      && adr_full[15:12] <= srr_pkg::REG_SEL_MAX;
    load = 1'b0;
    case (st_ff)
      srr_pkg::ST_CMD: begin
        if (cnt_ff == srr_pkg::OPC_LAST) begin
          nxt_cnt = srr_pkg::CNT_ZERO;
          if (opc_full == srr_pkg::OPC_READ && !b2_ff) begin
            nxt_st = srr_pkg::ST_ADR;
          end else begin
            nxt_st = srr_pkg::ST_IGNORE;
          end
        end
      end
      srr_pkg::ST_ADR: begin
        if (cnt_ff == srr_pkg::ADR_LAST) begin
          nxt_cnt = srr_pkg::CNT_ZERO;
          if (adr_ok) begin
            nxt_st = srr_pkg::ST_DUMMY;
            nxt_lreg = adr_full[13:12];
            nxt_lstart = adr_full[7:0];
            nxt_tog = ~tog_ff;
          end else begin
            nxt_st = srr_pkg::ST_IGNORE;
          end
        end
      end
      srr_pkg::ST_DUMMY: begin
        if (cnt_ff == srr_pkg::DUMMY_LAST) begin
          nxt_st = srr_pkg::ST_DATA;
          nxt_cnt = srr_pkg::CNT_ZERO;
          load = 1'b1;
        end
      end
      srr_pkg::ST_DATA: begin
        if (cnt_ff == srr_pkg::BIT_LAST) begin
          nxt_cnt = srr_pkg::CNT_ZERO;
          load = 1'b1;
        end
      end
      default: begin
        nxt_cnt = cnt_ff;
      end
    endcase
    if (load) begin
      nxt_sh = rdata[7:0];
    end
    // drop words left over from an earlier frame
    rready = load || (rvalid && rdata[8] != tog_ff);
  end

  // frame state, cleared whenever chip select is high
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      st_ff <= srr_pkg::ST_CMD;
      cnt_ff <= srr_pkg::CNT_ZERO;
      sr_ff <= '0;
      sh_ff <= '0;
      b1_ff <= 1'b0;
      b2_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sr_ff <= nxt_sr;
      sh_ff <= nxt_sh;
      b1_ff <= busy_ff;
      b2_ff <= b1_ff;
    end
  end

  // request held across frames for the fetch side
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_ff <= 1'b0;
      lreg_ff <= '0;
      lstart_ff <= '0;
    end else begin
      tog_ff <= nxt_tog;
      lreg_ff <= nxt_lreg;
      lstart_ff <= nxt_lstart;
    end
  end

  // output pin changes on falling edge, released at once by chip select
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      so_ff <= sh_ff[7];
      oe_ff <= st_ff == srr_pkg::ST_DATA;
    end
  end
  assign o_so = so_ff;
  assign o_so_oe = oe_ff;

  // ----------------------------------------
  // data buffer between the two clocks
  // ----------------------------------------
  srr_afifo #(.W(srr_pkg::FIFO_W), .DEPTH(srr_pkg::FIFO_DEPTH)) u_fifo (
    .i_wclk(i_ref_clk),
    .i_wrst_n(i_rst_n),
    .i_wvalid(wvalid),
    .o_wready(wready),
    .i_wdata(wdata),
    .i_rclk(i_sclk),
    .i_rrst_n(i_rst_n),
    .o_rvalid(rvalid),
    .i_rready(rready),
    .o_rdata(rdata)
  );

  // ----------------------------------------
  // fetch side, reference clock
  // ----------------------------------------
  // start on a new request toggle, then stream bytes into the buffer
  always_comb begin
    newreq = t2_ff != seen_ff;
    wvalid = act_ff && !newreq;
    wdata = {tag_ff, mem_ff[reg_ff][ptr_ff]};
    nxt_seen = t2_ff;
    nxt_act = act_ff || newreq;
    nxt_tag = tag_ff;
    nxt_reg = reg_ff;
    nxt_ptr = ptr_ff;
    if (newreq) begin
      nxt_tag = t2_ff;
      nxt_reg = lreg_ff - 2'h1;
      nxt_ptr = lstart_ff;
    end else if (wvalid && wready) begin
      nxt_ptr = ptr_ff + 8'h01;
    end
    // start wins over done
    nxt_busy = i_cycle_start ? 1'b1 : (i_cycle_done ? 1'b0 : busy_ff);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      t1_ff <= 1'b0;
      t2_ff <= 1'b0;
      seen_ff <= 1'b0;
      act_ff <= 1'b0;
      tag_ff <= 1'b0;
      reg_ff <= '0;
      ptr_ff <= srr_pkg::BYTE_FIRST;
      busy_ff <= 1'b0;
    end else begin
      t1_ff <= tog_ff;
      t2_ff <= t1_ff;
      seen_ff <= nxt_seen;
      act_ff <= nxt_act;
      tag_ff <= nxt_tag;
      reg_ff <= nxt_reg;
      ptr_ff <= nxt_ptr;
      busy_ff <= nxt_busy;
    end
  end
  assign o_busy = busy_ff;

  // register contents loaded by the program path
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en && i_wr_reg != 2'h0) begin
      mem_ff[i_wr_reg - 2'h1][i_wr_addr] <= i_wr_data;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_dummy;
    (st_ff == srr_pkg::ST_DUMMY) [*8] ##1 st_ff == srr_pkg::ST_DATA;
  endsequence
  sequence s_ignored;
    (st_ff == srr_pkg::ST_IGNORE && !oe_ff) [*4];
  endsequence

  property p_opc_take;
    @(posedge i_sclk) disable iff (i_cs_n)
    st_ff == srr_pkg::ST_CMD && cnt_ff == srr_pkg::OPC_LAST
      && opc_full == srr_pkg::OPC_READ && !b2_ff
      |=> st_ff == srr_pkg::ST_ADR;
  endproperty
  a_opc_take: assert property (p_opc_take)
    else $error("opcode not accepted");

  property p_dummy_len;
    @(posedge i_sclk) disable iff (i_cs_n)
    st_ff == srr_pkg::ST_ADR && cnt_ff == srr_pkg::ADR_LAST && adr_ok
      |=> s_dummy;
  endproperty
  a_dummy_len: assert property (p_dummy_len)
    else $error("dummy phase not eight clocks");

  property p_sample;
    @(posedge i_sclk) disable iff (i_cs_n)
    st_ff == srr_pkg::ST_ADR |=> sr_ff[0] == $past(i_serial_in_pin);
  endproperty
  a_sample: assert property (p_sample)
    else $error("address bit not sampled");

  property p_msb;
    @(posedge i_sclk) disable iff (i_cs_n)
    st_ff == srr_pkg::ST_DATA && $past(load) |-> so_ff == $past(rdata[7]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("byte not sent msb first");

  property p_inc;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    wvalid && wready |=> ptr_ff == $past(ptr_ff) + 8'h01;
  endproperty
  a_inc: assert property (p_inc)
    else $error("byte address did not advance");

  property p_wrap;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    wvalid && wready && ptr_ff == srr_pkg::BYTE_LAST
      |=> ptr_ff == srr_pkg::BYTE_FIRST && $stable(reg_ff);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("address did not wrap in register");

  property p_release;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_cs_n |-> !o_so_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("output driven with chip select high");

  property p_busy_ign;
    @(posedge i_sclk) disable iff (i_cs_n)
    st_ff == srr_pkg::ST_CMD && cnt_ff == srr_pkg::OPC_LAST && b2_ff
      |=> s_ignored;
  endproperty
  a_busy_ign: assert property (p_busy_ign)
    else $error("read accepted while busy");

  property p_bad_adr;
    @(posedge i_sclk) disable iff (i_cs_n)
    st_ff == srr_pkg::ST_ADR && cnt_ff == srr_pkg::ADR_LAST && !adr_ok
      |=> st_ff == srr_pkg::ST_IGNORE;
  endproperty
  a_bad_adr: assert property (p_bad_adr)
    else $error("bad address accepted");

  property p_busy_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_busy && !i_cycle_done |=> o_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped during cycle");

  property p_hiz;
    @(posedge i_sclk) disable iff (i_cs_n)
    st_ff != srr_pkg::ST_DATA |-> !oe_ff;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("output driven outside data phase");
endmodule // srr_read

//--- srr_pkg.sv
package srr_pkg;
  // ----------------------------------------
  // instruction and address layout
  // ----------------------------------------
  localparam logic [7:0] OPC_READ = 8'h48;
  localparam logic [7:0] ADR_HI_ZERO = 8'h00;
  localparam logic [3:0] ADR_MID_ZERO = 4'h0;
  localparam logic [3:0] REG_SEL_MIN = 4'h1;
  localparam logic [3:0] REG_SEL_MAX = 4'h3;
  localparam logic [7:0] BYTE_LAST = 8'hFF;
  localparam logic [7:0] BYTE_FIRST = 8'h00;
  localparam int NUM_REGS = 3;
  localparam int REG_BYTES = 256;
  // ----------------------------------------
  // serial phase lengths, as last count
  // ----------------------------------------
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] ADR_LAST = 5'h17;
  localparam logic [4:0] DUMMY_LAST = 5'h07;
  localparam logic [4:0] BIT_LAST = 5'h07;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  // ----------------------------------------
  // data buffer
  // ----------------------------------------
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 9;
  typedef enum logic [2:0] {
    ST_CMD, ST_ADR, ST_DUMMY, ST_DATA, ST_IGNORE
  } srr_state_t;
endpackage

//--- srr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host spi controller, 80 ns serial clock
// ----------------------------------------
module srr_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_serial_in_pin,
  input wire logic i_so,
  input wire logic i_so_oe
);
  logic [7:0] rx_q[$];
  logic early_oe;
  int oe_cnt;

  // idle: deselected, clock parked low; one rising select clears frame
  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h0;
    o_serial_in_pin = 1'h0;
    #1 o_cs_n = 1'h1;
  end

  // one frame: header bits, then data bits read on rising edges
  task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
                       input int n, input int extra);
    logic [39:0] hdr;
    logic [7:0] b;
    hdr = {opc, adr, 8'hA5};
    b = 8'h00;
    rx_q.delete();
    early_oe = 1'h0;
    oe_cnt = 0;
    o_cs_n = 1'h0; // select opens the instruction
    for (int i = 39; i >= 0; i--) begin
      o_serial_in_pin = hdr[i]; // header msb first
      #40 o_sclk = 1'h1;
      if (i_so_oe !== 1'h0) begin
        early_oe = 1'h1;
      end
      #40 o_sclk = 1'h0;
    end
    for (int i = 0; i < n * 8 + extra; i++) begin
      o_serial_in_pin = ~o_serial_in_pin; // input is don't care here
      #40 o_sclk = 1'h1;
      if (i_so_oe === 1'h1) begin
        oe_cnt++;
      end
      b = {b[6:0], ((i_so_oe === 1'h1) ? i_so : ~i_so)}; // released: inverse
      if (i % 8 == 7) begin
        rx_q.push_back(b);
      end
      #40 o_sclk = 1'h0;
    end
    #40 o_cs_n = 1'h1; // deselect ends the read
    o_serial_in_pin = ~o_serial_in_pin; // no stale level when released
  endtask
endmodule // srr_host_model

//--- srr_read_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
// ----------------------------------------
// testbench top
// ----------------------------------------
module srr_read_tb;
  logic ref_clk, rst_n, sclk, cs_n, sdi, so, so_oe, busy;
  logic cycle_start, cycle_done, wr_en;
  logic [1:0] wr_reg;
  logic [7:0] wr_addr, wr_data;
  int err_total = 0;
  int compares = 0;

  srr_read dut_u (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_serial_in_pin(sdi), .o_so(so), .o_so_oe(so_oe),
    .i_cycle_start(cycle_start), .i_cycle_done(cycle_done),
    .o_busy(busy), .i_wr_en(wr_en), .i_wr_reg(wr_reg),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data));
  srr_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n),
    .o_serial_in_pin(sdi), .i_so(so), .i_so_oe(so_oe));

  // 100 ns reference clock
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] pat(input logic [1:0] r,
                                     input logic [7:0] a);
    return a ^ {r, 6'h15};
  endfunction

  task automatic load(input logic [1:0] r, input logic [7:0] a);
    @(negedge ref_clk);
    wr_en = 1'h1;
    wr_reg = r;
    wr_addr = a;
    wr_data = pat(r, a);
  endtask

  // one-cycle pulse on the cycle start and done inputs
  task automatic pulse(input logic start, input logic done);
    @(negedge ref_clk);
    cycle_start = start;
    cycle_done = done;
    @(negedge ref_clk);
    cycle_start = 1'h0;
    cycle_done = 1'h0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] opc, input logic [23:0] adr,
                    input int n, input int extra);
    host_u.frame(opc, adr, n, extra);
    #1;
    `CHK(so_oe, 1'h0) // output off at deselect
    #500;
  endtask

  task automatic chk_good(input int nbits);
    `CHK(host_u.early_oe, 1'h0) // quiet before data
    `CHK(host_u.oe_cnt, nbits) // driving through data
  endtask

  task automatic t_load;
    for (int i = 0; i < 3; i++) begin
      load(2'h1, 8'h05 + 8'(i));
      load(2'h3, 8'hFE + 8'(i));
      load(2'(i + 1), 8'h10);
    end
    load(2'h0, 8'h06);
    @(negedge ref_clk);
    wr_en = 1'h0;
    $display("test load done");
  endtask

  task automatic t_seq;
    rd(8'h48, 24'h001005, 3, 0);
    chk_good(24);
    for (int i = 0; i < 3; i++) begin
      `CHK(host_u.rx_q[i], pat(2'h1, 8'h05 + 8'(i))) // msb first
    end
    $display("test seq done");
  endtask

  task automatic t_wrap;
    rd(8'h48, 24'h0030FE, 3, 0);
    chk_good(24);
    for (int i = 0; i < 3; i++) begin
      `CHK(host_u.rx_q[i], pat(2'h3, 8'hFE + 8'(i))) // wraps in reg
    end
    $display("test wrap done");
  endtask

  task automatic t_regs;
    for (int r = 1; r <= 3; r++) begin
      rd(8'h48, {10'h000, 2'(r), 12'h010}, 1, 0);
      chk_good(8);
      `CHK(host_u.rx_q[0], pat(2'(r), 8'h10)) // register select
    end
    $display("test regs done");
  endtask

  task automatic t_refuse;
    logic [31:0] bad [5] = '{32'h03001010, 32'h48011010, 32'h48001110,
                             32'h48004010, 32'h48000010};
    for (int i = 0; i < 5; i++) begin
      rd(bad[i][31:24], bad[i][23:0], 1, 0);
      `CHK(host_u.oe_cnt, 0) // refused frame stays silent
    end
    $display("test refuse done");
  endtask

  task automatic t_busy;
    pulse(1'h1, 1'h0);
    `CHK(busy, 1'h1) // busy set by cycle start
    pulse(1'h1, 1'h1);
    `CHK(busy, 1'h1) // start wins over done
    rd(8'h48, 24'h001005, 1, 0);
    `CHK(host_u.oe_cnt, 0) // read ignored while busy
    `CHK(busy, 1'h1) // cycle left running
    pulse(1'h0, 1'h1);
    `CHK(busy, 1'h0) // busy clears at cycle end
    rd(8'h48, 24'h001005, 1, 0);
    chk_good(8);
    `CHK(host_u.rx_q[0], pat(2'h1, 8'h05)) // read works again
    $display("test busy done");
  endtask

  task automatic t_abort;
    rd(8'h48, 24'h001005, 1, 3);
    chk_good(11);
    `CHK(host_u.rx_q[0], pat(2'h1, 8'h05)) // first byte whole
    rd(8'h48, 24'h001006, 1, 0);
    chk_good(8);
    `CHK(host_u.rx_q[0], pat(2'h1, 8'h06)) // fresh instruction
    $display("test abort done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'h1;
    cycle_start = 1'h0;
    cycle_done = 1'h0;
    wr_en = 1'h0;
    wr_reg = 2'h0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    #1 rst_n = 1'h0; // a real falling edge clears link-side state
    repeat (8) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    `CHK(busy, 1'h0) // idle after reset
    t_load;
    t_seq;
    t_wrap;
    t_regs;
    t_refuse;
    t_busy;
    t_abort;
    tally_and_finish;
  end

  // hang guard, about twenty times the expected run
  initial begin
    #1500000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish;
  end
endmodule // srr_read_tb
